// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import timer_evt_pkg::*;
  logic i_clk_sys = 0, i_sys_rst = 1, i_avs_read = 0, i_avs_write = 0;
  logic [7:0] i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic i_update_disable = 0, i_update_source_select = 0, i_repetition_overrun = 0;
  logic i_trigger_reinit = 0, o_avs_waitrequest, o_update_event, o_counter_reinit;
  logic o_update_dma_req, o_irq;
  logic [15:0] i_counter_value = 16'h5a5a, cmp1 = 16'h1234, cmp2 = 16'h12cb;
  logic [15:0] o_event_request_enable;
  logic [1:0] i_chan_is_input = 2'h0, i_chan_capture = 2'h0, i_chan_capture_read = 2'h0;
  logic [1:0] o_chan_dma_req;
  int err_total = 0, n_tests = 0, sts = 0, en = 0, k, d, m, mm;
  // ---------------------------------------------------------------
  // Clock, design and checker
  // ---------------------------------------------------------------
  always #4 i_clk_sys = ~i_clk_sys;
  timer_event_enable_status dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_update_disable(i_update_disable), .i_update_source_select(i_update_source_select),
    .i_repetition_overrun(i_repetition_overrun), .i_trigger_reinit(i_trigger_reinit),
    .i_counter_value(i_counter_value), .i_chan_is_input(i_chan_is_input),
    .i_chan1_compare_capture(cmp1), .i_chan2_compare_capture(cmp2),
    .i_chan_capture(i_chan_capture), .i_chan_capture_read(i_chan_capture_read),
    .o_update_event(o_update_event), .o_counter_reinit(o_counter_reinit),
    .o_update_dma_req(o_update_dma_req), .o_chan_dma_req(o_chan_dma_req),
    .o_event_request_enable(o_event_request_enable), .o_irq(o_irq));
  // Verdict, reached from the main flow or a bus timeout
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One bus cycle; request held until waitrequest seen low
  task automatic xfer(input bit wr, input logic [7:0] a, input int dd, input logic [3:0] be);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_writedata <= dd;
    i_avs_byteenable <= be;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    if (o_avs_waitrequest !== 1'b0) begin
      err_total++;
      wrap_up();
    end else begin
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask
  // Status, interrupt line and enables against the model
  task automatic chk();
    xfer(0, OFS_EVENT_STATUS_FLAGS, 0, 4'hf);
    `CHK("status", sts, q)
    `CHK("irq", |(sts & en & 7), o_irq)
    xfer(0, OFS_EVENT_REQUEST_ENABLE, 0, 4'hf);
    `CHK("enable", en, q)
    `CHK("enable_port", en, o_event_request_enable)
  endtask
  // One-cycle event pulse; counter returns to a value matching neither channel
  task automatic fire(int kk);
    case (kk)
      0: i_repetition_overrun <= 1'b1;
      1: i_trigger_reinit <= 1'b1;
      2, 3: i_chan_capture <= 2'(1 << (kk - 2));
      4, 5: i_chan_capture_read <= 2'(1 << (kk - 4));
      6: i_counter_value <= cmp1;
      7: i_counter_value <= cmp2;
      default: ;
    endcase
    @(posedge i_clk_sys);
    i_repetition_overrun <= 1'b0;
    i_trigger_reinit <= 1'b0;
    i_chan_capture <= 2'h0;
    i_chan_capture_read <= 2'h0;
    i_counter_value <= 16'h5a5a;
    @(posedge i_clk_sys);
  endtask
  // Random mix of events, modes and register traffic
  initial begin
    void'($urandom(32'hfea01845));
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
    chk();
    for (int i = 0; i < 400; i++) begin
      // Mid-run reset: every register and flag returns to zero
      if (i == 200) begin
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        sts = 0;
        en = 0;
        @(posedge i_clk_sys);
      end
      d = $urandom;
      m = $urandom;
      k = $urandom_range(12, 0);
      i_update_disable <= (m[7:6] == 2'b00);
      i_update_source_select <= m[5];
      i_chan_is_input <= m[9:8];
      @(posedge i_clk_sys);
      fire(k);
      case (k)
        0: if (!i_update_disable) sts |= 1;
        1: if (!i_update_disable && !i_update_source_select) sts |= 1;
        2, 3: if (i_chan_is_input[k-2]) sts |= 2 << (k - 2);
        4, 5: if (i_chan_is_input[k-4]) sts &= ~(2 << (k - 4));
        6, 7: if (!i_chan_is_input[k-6]) sts |= 2 << (k - 6);
        8: begin
          xfer(1, OFS_EVENT_GENERATION, 1, 4'h1);
          if (!i_update_disable && !i_update_source_select) sts |= 1;
        end
        9: begin
          xfer(1, OFS_EVENT_STATUS_FLAGS, d, 4'h1);
          sts &= d;
        end
        10: begin
          xfer(1, OFS_EVENT_STATUS_CLEAR, d, 4'h1);
          sts &= ~d;
        end
        11: begin
          xfer(1, OFS_EVENT_REQUEST_ENABLE, d, m[13:10]);
          mm = {(m[11] ? 8'hff : 8'h00), (m[10] ? 8'hff : 8'h00)} & 16'h7fff;
          en = (en & ~mm) | (d & mm);
        end
        default: begin
          xfer(0, 8'h14 | (d & 8'he8), 0, 4'hf);
          `CHK("unmapped", 0, q)
        end
      endcase
      chk();
    end
    wrap_up();
  end
endmodule // tb_top
bind timer_event_enable_status timer_evt_sva sva (.i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
  .i_update_disable(i_update_disable), .i_update_source_select(i_update_source_select),
  .i_repetition_overrun(i_repetition_overrun), .i_trigger_reinit(i_trigger_reinit),
  .o_update_event(o_update_event), .o_counter_reinit(o_counter_reinit),
  .o_update_dma_req(o_update_dma_req),
  .o_chan_dma_req(o_chan_dma_req), .o_event_request_enable(o_event_request_enable),
  .o_irq(o_irq));

// File: dv/timer_evt_sva.sv
`timescale 1ns/1ps
module timer_evt_sva
  import timer_evt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic i_update_disable,
  input wire logic i_update_source_select,
  input wire logic i_repetition_overrun,
  input wire logic i_trigger_reinit,
  input wire logic o_update_event,
  input wire logic o_counter_reinit,
  input wire logic o_update_dma_req,
  input wire logic [1:0] o_chan_dma_req,
  input wire logic [15:0] o_event_request_enable,
  input wire logic o_irq
);
  // ---------------------------------------------------------------
  // Checks on the block's ports
  // ---------------------------------------------------------------
  logic en_wr;
  // Accepted write to the enable register, whatever the byte lanes
  assign en_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == OFS_EVENT_REQUEST_ENABLE;
  logic gen_wr;
  // Accepted write to the generate register, whatever the data
  assign gen_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == OFS_EVENT_GENERATION;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_bus_one_wait: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_enable_write: assert property (
    en_wr && i_avs_byteenable[1:0] == 2'b11 |=>
    o_event_request_enable == ($past(i_avs_writedata[15:0]) & ENABLE_WRITE_MASK))
    else $error("enable register did not take write data");
  a_overrun_event: assert property (
    i_repetition_overrun && !i_update_disable |=> o_update_event)
    else $error("no update event after overrun");
  a_disable_blocks: assert property (
    i_update_disable |=> !o_update_event) else $error("update event while disabled");
  a_trigger_event: assert property (
    i_trigger_reinit && !i_update_disable && !i_update_source_select |=> o_update_event)
    else $error("no update event after trigger");
  a_update_irq: assert property (
    i_repetition_overrun && !i_update_disable && o_event_request_enable[0] && !en_wr
    |=> o_irq) else $error("no interrupt after enabled update");
  a_irq_masked: assert property (
    o_event_request_enable[2:0] == 3'h0 |-> !o_irq) else $error("interrupt while masked");
  a_update_dma: assert property (
    o_update_dma_req == (o_update_event && $past(o_event_request_enable[8])))
    else $error("update dma request mismatch");
  a_chan_dma: assert property (
    o_chan_dma_req[0] |-> $past(o_event_request_enable[9]))
    else $error("channel dma request without enable");
  a_chan2_dma: assert property (
    o_chan_dma_req[1] |-> $past(o_event_request_enable[10]))
    else $error("channel 2 dma request without enable");
  a_reinit_pulse: assert property (
    gen_wr && i_avs_byteenable[0] && i_avs_writedata[0] && !i_update_disable
    |=> o_counter_reinit) else $error("no counter reinit after generate write");
  a_reinit_cause: assert property (
    o_counter_reinit |-> $past(gen_wr)) else $error("counter reinit without generate write");
endmodule // timer_evt_sva

// File: hw/chan_event_detect.sv
`timescale 1ns/1ps
module chan_event_detect
  import timer_evt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_is_input,
  input wire logic [15:0] i_counter_value,
  input wire logic [15:0] i_compare_value,
  input wire logic i_capture,
  input wire logic i_capture_read,
  output logic o_flag_set,
  output logic o_flag_clear
);

  // ---------------------------------------------------------------
  // Compare match and capture detection
  // ---------------------------------------------------------------
  logic match_now;
  logic match_prev;

  assign match_now = (i_counter_value == i_compare_value);

  // Remember last match so a stalled counter does not re-set forever
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= match_now;
    end
  end

  // Output mode flags the first cycle of a match, input mode each capture
  assign o_flag_set = i_is_input ? i_capture : (match_now && !match_prev); // R07 R08
  // Reading the capture register only clears in input mode
  assign o_flag_clear = i_is_input && i_capture_read; // R08

endmodule // chan_event_detect

// File: hw/timer_event_enable_status.sv
// Overview of operation
// R01: Bits 0-7 enable update, channel, commutation, trigger, break irqs; only bits 0-2 drive o_irq here
// R02: Bits 8-14 enable DMA requests; bit 15 reserved; only bits 8-10 drive DMA requests here
// R03: Update flag set by reload, held until zero written; a one written to the clear register also clears it here
// R04: Repetition overrun sets update flag unless disabled
// R05: Update generate bit sets flag when source select zero
// R06: Trigger reinit sets flag when source select zero
// R07: Output channel 1 flag set on compare match
// R08: Input channel 1 flag: capture sets, write0/read clears
// R09: Channel 2 flag behaves like channel 1
// R10: Irq while enabled flag set; writing one keeps flag
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
module timer_event_enable_status
  import timer_evt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Control bits from the timer control block
  input wire logic i_update_disable,
  input wire logic i_update_source_select,
  // Events from the counter core
  input wire logic i_repetition_overrun,
  input wire logic i_trigger_reinit,
  input wire logic [15:0] i_counter_value,
  // Channel 1 and 2 side, index 0 is channel 1
  input wire logic [1:0] i_chan_is_input,
  input wire logic [15:0] i_chan1_compare_capture,
  input wire logic [15:0] i_chan2_compare_capture,
  input wire logic [1:0] i_chan_capture,
  input wire logic [1:0] i_chan_capture_read,
  // Results
  output logic o_update_event,
  output logic o_counter_reinit,
  output logic o_update_dma_req,
  output logic [1:0] o_chan_dma_req,
  output logic [15:0] o_event_request_enable,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // Bus access decode
  // ---------------------------------------------------------------
  logic ack;
  logic wr_fire;
  logic rd_fire;

  // Shared address compare, used by every register strobe
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // One wait cycle gives time to register read data
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;
  assign wr_fire = i_avs_write && ack;
  assign rd_fire = i_avs_read && ack;

  // Ack lasts one cycle so back-to-back requests each wait once
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read || i_avs_write) && !ack;
    end
  end

  logic wr_enable;
  logic wr_status;
  logic wr_generate;
  logic wr_clear;

  assign wr_enable = wr_fire && hit(i_avs_address, OFS_EVENT_REQUEST_ENABLE);
  assign wr_status = wr_fire && hit(i_avs_address, OFS_EVENT_STATUS_FLAGS);
  assign wr_generate = wr_fire && hit(i_avs_address, OFS_EVENT_GENERATION);
  assign wr_clear = wr_fire && hit(i_avs_address, OFS_EVENT_STATUS_CLEAR);

  // ---------------------------------------------------------------
  // Enable register
  // ---------------------------------------------------------------
  logic [15:0] event_request_enable;
  logic [15:0] next_enable_lanes;

  // Byte lanes merge into the old value; reserved bit stays zero
  always_comb begin
    next_enable_lanes = event_request_enable;
    if (i_avs_byteenable[0]) begin
      next_enable_lanes[7:0] = i_avs_writedata[7:0];
    end
    if (i_avs_byteenable[1]) begin
      next_enable_lanes[15:8] = i_avs_writedata[15:8];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      event_request_enable <= RST_EVENT_REQUEST_ENABLE;
    end else if (wr_enable) begin
      event_request_enable <= next_enable_lanes & ENABLE_WRITE_MASK; // R01 R02
    end
  end

  assign o_event_request_enable = event_request_enable;

  // ---------------------------------------------------------------
  // Update event source
  // ---------------------------------------------------------------
  logic update_generate;
  logic update_event;
  logic update_flag_set;

  // Generate bit is write-only and self-clearing: a pulse on the write
  assign update_generate = wr_generate && i_avs_byteenable[0] &&
    i_avs_writedata[POS_UPDATE_GENERATE];

  update_event_gen u_update_event_gen (
    .i_update_disable(i_update_disable),
    .i_update_source_select(i_update_source_select),
    .i_repetition_overrun(i_repetition_overrun),
    .i_trigger_reinit(i_trigger_reinit),
    .i_update_generate(update_generate),
    .o_update_event(update_event),
    .o_update_flag_set(update_flag_set)
  );

  // Registered so the core sees clean single-cycle pulses
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_update_event <= 1'b0;
      o_counter_reinit <= 1'b0;
      o_update_dma_req <= 1'b0;
    end else begin
      o_update_event <= update_event;
      o_counter_reinit <= update_generate && !i_update_disable; // R05
      o_update_dma_req <= update_event && event_request_enable[POS_UPDATE_DMA];
    end
  end

  // ---------------------------------------------------------------
  // Channel compare and capture detection
  // ---------------------------------------------------------------
  logic [NUM_CHAN-1:0] chan_flag_set;
  logic [NUM_CHAN-1:0] chan_flag_clear;
  logic [15:0] chan_compare [NUM_CHAN];

  assign chan_compare[0] = i_chan1_compare_capture;
  assign chan_compare[1] = i_chan2_compare_capture;

  // Channel 2 reuses the channel 1 detector unchanged
  generate
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      chan_event_detect u_detect (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_is_input(i_chan_is_input[g]),
        .i_counter_value(i_counter_value),
        .i_compare_value(chan_compare[g]),
        .i_capture(i_chan_capture[g]),
        .i_capture_read(i_chan_capture_read[g]),
        .o_flag_set(chan_flag_set[g]),
        .o_flag_clear(chan_flag_clear[g])
      ); // R07 R08 R09
    end
  endgenerate

  // DMA request follows each channel event when enabled
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_chan_dma_req <= '0;
    end else begin
      o_chan_dma_req <= chan_flag_set &
        event_request_enable[POS_CHAN1_DMA +: NUM_CHAN];
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic [2:0] event_status_flags;
  logic [2:0] flag_set;
  logic [2:0] flag_sw_clear;
  logic [2:0] flag_clear;

  assign flag_set = {chan_flag_set, update_flag_set};

  // Status writes: zero clears, one leaves the flag alone; clear-register writes: one clears
  always_comb begin
    flag_sw_clear = '0;
    if (wr_status && i_avs_byteenable[0]) begin
      flag_sw_clear = ~i_avs_writedata[2:0]; // R10
    end
    if (wr_clear && i_avs_byteenable[0]) begin
      flag_sw_clear = flag_sw_clear | i_avs_writedata[2:0];
    end
  end

  // Capture-register reads clear only the channel flags
  assign flag_clear = flag_sw_clear | {chan_flag_clear, 1'b0}; // R08 R09

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      event_status_flags <= RST_EVENT_STATUS_FLAGS;
    end else begin
      event_status_flags <= flag_set | (event_status_flags & ~flag_clear); // R03 R07 R09
    end
  end

  // ---------------------------------------------------------------
  // Interrupt output
  // ---------------------------------------------------------------
  // Level output; stays high until software clears the flag
  assign o_irq = |(event_status_flags &
    event_request_enable[POS_IRQ_ENABLE_LO +: 3]); // R10

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] next_readdata;

  // Write-only and unmapped locations read as zero
  always_comb begin
    next_readdata = RST_READ_DATA;
    if (hit(i_avs_address, OFS_EVENT_REQUEST_ENABLE)) begin
      next_readdata[15:0] = event_request_enable;
    end else if (hit(i_avs_address, OFS_EVENT_STATUS_FLAGS)) begin
      next_readdata[2:0] = event_status_flags;
    end
  end

  // Captured in the wait cycle, stands while waitrequest is low
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_avs_readdata <= RST_READ_DATA;
    end else if (i_avs_read && !ack) begin
      o_avs_readdata <= next_readdata;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_fire;

endmodule // timer_event_enable_status

// File: hw/timer_evt_pkg.sv
package timer_evt_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT_REQUEST_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_EVENT_STATUS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_EVENT_GENERATION = 8'h14;
  localparam logic [7:0] OFS_EVENT_STATUS_CLEAR = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  // Interrupt enables sit in bits 0..7, DMA enables in bits 8..14
  localparam int POS_IRQ_ENABLE_LO = 0;
  localparam int POS_IRQ_ENABLE_HI = 7;
  localparam int POS_DMA_ENABLE_LO = 8;
  localparam int POS_DMA_ENABLE_HI = 14;
  localparam int POS_UPDATE = 0;
  localparam int POS_CHAN1 = 1;
  localparam int POS_CHAN2 = 2;
  localparam int POS_UPDATE_DMA = 8;
  localparam int POS_CHAN1_DMA = 9;
  localparam int POS_UPDATE_GENERATE = 0;
  localparam int NUM_CHAN = 2;

  // Writable bits of the enable register; bit 15 is reserved
  localparam logic [15:0] ENABLE_WRITE_MASK = 16'h7fff;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_EVENT_REQUEST_ENABLE = 16'h0000;
  localparam logic [2:0] RST_EVENT_STATUS_FLAGS = 3'h0;
  localparam logic [31:0] RST_READ_DATA = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Bus timing: cycles from request to waitrequest low
  // ---------------------------------------------------------------
  localparam int BUS_WAIT_CYCLES = 1;

endpackage

// File: hw/update_event_gen.sv
`timescale 1ns/1ps
module update_event_gen
  import timer_evt_pkg::*;
(
  input wire logic i_update_disable,
  input wire logic i_update_source_select,
  input wire logic i_repetition_overrun,
  input wire logic i_trigger_reinit,
  input wire logic i_update_generate,
  output logic o_update_event,
  output logic o_update_flag_set
);

  // ---------------------------------------------------------------
  // Update event qualification
  // ---------------------------------------------------------------
  // Any reload source makes an update event unless updates are disabled
  assign o_update_event = !i_update_disable &&
    (i_repetition_overrun || i_update_generate || i_trigger_reinit);

  // Software and trigger sources only raise the flag with source select low
  always_comb begin
    o_update_flag_set = 1'b0;
    if (!i_update_disable) begin
      if (i_repetition_overrun) begin
        o_update_flag_set = 1'b1; // R03 R04
      end
      if (!i_update_source_select && i_update_generate) begin
        o_update_flag_set = 1'b1; // R05
      end
      if (!i_update_source_select && i_trigger_reinit) begin
        o_update_flag_set = 1'b1; // R06
      end
    end
  end

endmodule // update_event_gen
